// File: hw/l1pd_caches.sv
`timescale 1ns/100ps
`default_nettype none
module l1pd_caches (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	// program fetch port
	input  wire l1pd_pkg::l1pd_core_req_t pf_req,
	output logic                        pf_ready,
	output logic                        pf_rvalid,
	output logic [31:0]                 pf_rdata,
	// data port
	input  wire l1pd_pkg::l1pd_core_req_t dc_req,
	output logic                        dc_ready,
	output logic                        dc_rvalid,
	output logic [31:0]                 dc_rdata,
	// second-level memory port
	output var l1pd_pkg::l1pd_sl_req_t  sl_req,
	input  wire logic                   sl_ack,
	input  wire logic [l1pd_pkg::SL_RD_W-1:0] sl_rdata
);
	import l1pd_pkg::*;

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [P_LINE_BITS-1:0] p_data [P_LINES];
	logic [P_TAG_W-1:0]     p_tag  [P_LINES];
	logic [D_LINE_BITS-1:0] d_data [D_WAYS][D_SETS];
	logic [D_TAG_W-1:0]     d_tag  [D_WAYS][D_SETS];

	l1pd_regs_t         r;
	l1pd_regs_t         next_r;
	logic [P_IDX_W-1:0] pi;
	logic [D_IDX_W-1:0] di;
	logic [D_IDX_W-1:0] mi;
	logic               p_hit;
	logic               p_miss;
	logic [1:0]         dh;
	logic               d_hit;
	logic               dway;
	logic               idle;
	logic               d_take;
	logic               p_fill_we;
	logic               d_fill_we;
	logic               d_hit_we;

	assign idle  = (r.st == ST_IDLE);
	assign pi    = pf_req.addr[P_OFF_W +: P_IDX_W];
	assign di    = dc_req.addr[D_OFF_W +: D_IDX_W];
	assign mi    = r.maddr[D_OFF_W +: D_IDX_W];
	assign p_hit = r.p_valid[pi] &&
		(p_tag[pi] == pf_req.addr[ADDR_W-1 -: P_TAG_W]);
	assign p_miss = pf_req.req && !pf_req.we && !p_hit;
	always_comb begin
		for (int w = 0; w < D_WAYS; w++) begin
			dh[w] = r.d_valid[w][di] &&
				(d_tag[w][di] == dc_req.addr[ADDR_W-1 -: D_TAG_W]);
		end
	end
	assign d_hit  = |dh;
	assign dway   = dh[1];
	assign d_take = idle && dc_req.req && d_hit;

	// writes are taken and dropped: nothing in the array changes
	assign pf_ready = idle && pf_req.req && (pf_req.we || p_hit);
	// a forwarded write completes on the second-level acknowledge
	assign dc_ready = d_take || (r.st == ST_D_WMISS && sl_ack);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_r = r;
		next_r.pf_rvalid = 1'b0;
		next_r.dc_rvalid = 1'b0;
		p_fill_we = 1'b0;
		d_fill_we = 1'b0;
		d_hit_we  = 1'b0;
		if (pf_ready && !pf_req.we) begin
			next_r.pf_rvalid = 1'b1;
			next_r.pf_rdata  = p_data[pi][{pf_req.addr[5:2], 5'h0} +: 32];
		end
		if (d_take) begin
			next_r.lru[di] = ~dway;
			if (dc_req.we) begin
				d_hit_we = 1'b1;
				next_r.d_dirty[dway][di] = 1'b1;
			end else begin
				next_r.dc_rvalid = 1'b1;
				next_r.dc_rdata  = d_data[dway][di][{dc_req.addr[4:2], 5'h0} +: 32];
			end
		end
		case (r.st)
		ST_IDLE: begin
			// program misses win the shared port; one miss at a time
			if (p_miss) begin
				next_r.st      = ST_P_FILL;
				next_r.half    = 1'b0;
				next_r.cnt     = 3'h0;
				next_r.maddr   = {pf_req.addr[ADDR_W-1:P_OFF_W], 6'h0};
				next_r.p_valid[pi] = 1'b0;
				next_r.sl.req  = 1'b1;
				next_r.sl.we   = 1'b0;
				next_r.sl.addr = {pf_req.addr[ADDR_W-1:P_OFF_W], 6'h0};
				next_r.sl.wbe  = '0;
			end else if (dc_req.req && !d_hit) begin
				next_r.maddr  = {dc_req.addr[ADDR_W-1:D_OFF_W], 5'h0};
				next_r.way    = r.lru[di];
				next_r.half   = 1'b0;
				next_r.sl.req = 1'b1;
				if (dc_req.we) begin
					next_r.st       = ST_D_WMISS;
					next_r.sl.we    = 1'b1;
					next_r.sl.addr  = {dc_req.addr[ADDR_W-1:2], 2'h0};
					next_r.sl.wdata = {4{dc_req.wdata}};
					next_r.sl.wbe   = SL_BE_W'(dc_req.be) << {dc_req.addr[3:2], 2'h0};
				end else if (r.d_valid[r.lru[di]][di] && r.d_dirty[r.lru[di]][di]) begin
					next_r.st       = ST_D_WB;
					next_r.sl.we    = 1'b1;
					next_r.sl.addr  = {d_tag[r.lru[di]][di], di, 5'h0};
					next_r.sl.wdata = d_data[r.lru[di]][di][SL_WR_W-1:0];
					next_r.sl.wbe   = '1;
				end else begin
					next_r.st      = ST_D_FILL;
					next_r.d_valid[r.lru[di]][di] = 1'b0;
					next_r.sl.we   = 1'b0;
					next_r.sl.addr = {dc_req.addr[ADDR_W-1:D_OFF_W], 5'h0};
					next_r.sl.wbe  = '0;
				end
			end
		end
		ST_P_FILL: begin
			// the stall floor holds even when second level answers fast
			if (r.cnt != P_FILL_MIN) begin
				next_r.cnt = r.cnt + 3'h1;
			end
			if (r.sl.req && sl_ack) begin
				p_fill_we = 1'b1;
				if (r.half) begin
					next_r.sl.req = 1'b0;
					next_r.p_valid[r.maddr[P_OFF_W +: P_IDX_W]] = 1'b1;
				end else begin
					next_r.half    = 1'b1;
					next_r.sl.addr = r.maddr | P_HALF_STEP;
				end
			end
			if (!r.sl.req && r.cnt == P_FILL_MIN) begin
				next_r.st = ST_IDLE;
			end
		end
		ST_D_WB: begin
			if (sl_ack) begin
				if (!r.half) begin
					next_r.half     = 1'b1;
					next_r.sl.addr  = r.sl.addr | D_HALF_STEP;
					next_r.sl.wdata = d_data[r.way][mi][D_LINE_BITS-1 -: SL_WR_W];
				end else begin
					next_r.st      = ST_D_FILL;
					next_r.half    = 1'b0;
					next_r.d_valid[r.way][mi] = 1'b0;
					next_r.sl.we   = 1'b0;
					next_r.sl.wbe  = '0;
					next_r.sl.addr = r.maddr;
				end
			end
		end
		ST_D_FILL: begin
			if (sl_ack) begin
				d_fill_we = 1'b1;
				if (r.half) begin
					next_r.st     = ST_IDLE;
					next_r.sl.req = 1'b0;
					next_r.d_valid[r.way][mi] = 1'b1;
					next_r.d_dirty[r.way][mi] = 1'b0;
					next_r.lru[mi] = ~r.way;
				end else begin
					next_r.half    = 1'b1;
					next_r.sl.addr = r.maddr | D_HALF_STEP;
				end
			end
		end
		ST_D_WMISS: begin
			if (sl_ack) begin
				next_r.st     = ST_IDLE;
				next_r.sl.req = 1'b0;
				next_r.sl.we  = 1'b0;
			end
		end
		default: begin
			next_r.st = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// arrays: no reset, the valid bits guard them
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (p_fill_we) begin
			p_data[r.maddr[P_OFF_W +: P_IDX_W]][{r.half, 8'h0} +: 256] <= sl_rdata;
			p_tag[r.maddr[P_OFF_W +: P_IDX_W]] <= r.maddr[ADDR_W-1 -: P_TAG_W];
		end
		if (d_fill_we) begin
			d_data[r.way][mi][{r.half, 7'h0} +: SL_WR_W] <= sl_rdata[SL_WR_W-1:0];
			d_tag[r.way][mi] <= r.maddr[ADDR_W-1 -: D_TAG_W];
		end
		if (d_hit_we) begin
			for (int b = 0; b < 4; b++) begin
				if (dc_req.be[b]) begin
					d_data[dway][di][{dc_req.addr[4:2], 2'(b), 3'h0} +: 8] <=
						dc_req.wdata[8*b +: 8];
				end
			end
		end
	end

	assign pf_rvalid = r.pf_rvalid;
	assign pf_rdata  = r.pf_rdata;
	assign dc_rvalid = r.dc_rvalid;
	assign dc_rdata  = r.dc_rdata;
	assign sl_req    = r.sl;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_idle_no_request: assert property (
		idle |-> !r.sl.req) else $error("request open while idle");
	a_pmiss_stall: assert property (
		idle && p_miss |=> !pf_ready [*4]) else $error("program miss stall short");
	a_pwrite_ignored: assert property (
		pf_ready && pf_req.we |=> !pf_rvalid && $stable(r.p_valid))
		else $error("program write had effect");
	a_phit_one_cycle: assert property (
		pf_ready && !pf_req.we |=> pf_rvalid) else $error("program hit late");
	a_pfill_two_half: assert property (
		r.st == ST_P_FILL && sl_ack && r.sl.req && !r.half |=>
		r.sl.req && r.sl.addr == ($past(r.sl.addr) | P_HALF_STEP))
		else $error("program fill second half wrong");
	a_dfill_done: assert property (
		r.st == ST_D_FILL && sl_ack && r.half |=>
		idle && r.d_valid[$past(r.way)][$past(mi)])
		else $error("data fill did not validate line");
	a_wmiss_forward: assert property (
		idle && !p_miss && dc_req.req && dc_req.we && !d_hit |=>
		r.sl.req && r.sl.we && r.st == ST_D_WMISS) else $error("write miss lost");
	a_whit_dirty: assert property (
		// a program miss may open a read in the same cycle; only writes count
		d_take && dc_req.we |=> r.d_dirty[$past(dway)][$past(di)] &&
		!(r.sl.req && r.sl.we))
		else $error("write hit not dirty");
	a_victim_first: assert property (
		r.st == ST_D_WB |-> r.sl.req && r.sl.we) else $error("victim not written");
	a_dread_miss: assert property (
		idle && !p_miss && dc_req.req && !dc_req.we && !d_hit |=>
		!dc_rvalid && (r.st == ST_D_FILL || r.st == ST_D_WB))
		else $error("read miss did not allocate");

endmodule
`default_nettype wire

// File: hw/l1pd_pkg.sv
package l1pd_pkg;

	// ****************************************************************
	// geometry
	// ****************************************************************
	localparam int ADDR_W      = 32;
	localparam int P_OFF_W     = 6;
	localparam int P_IDX_W     = 6;
	localparam int P_TAG_W     = ADDR_W - P_OFF_W - P_IDX_W;
	localparam int P_LINES     = 64;
	localparam int P_LINE_BITS = 512;
	localparam int D_OFF_W     = 5;
	localparam int D_IDX_W     = 6;
	localparam int D_TAG_W     = ADDR_W - D_OFF_W - D_IDX_W;
	localparam int D_SETS      = 64;
	localparam int D_WAYS      = 2;
	localparam int D_LINE_BITS = 256;
	localparam int SL_RD_W     = 256;
	localparam int SL_WR_W     = 128;
	localparam int SL_BE_W     = SL_WR_W / 8;

	// ****************************************************************
	// fill halves and timing
	// ****************************************************************
	localparam logic [31:0] P_HALF_STEP = 32'h0000_0020;
	localparam logic [31:0] D_HALF_STEP = 32'h0000_0010;
	localparam int          P_MISS_STALL_CYC = 5;
	localparam logic [2:0]  P_FILL_MIN = 3'(P_MISS_STALL_CYC - 2);

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_P_FILL  = 3'b001,
		ST_D_WB    = 3'b010,
		ST_D_FILL  = 3'b011,
		ST_D_WMISS = 3'b100
	} l1pd_state_t;

	typedef struct packed {
		logic              req;
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic [3:0]        be;
	} l1pd_core_req_t;

	typedef struct packed {
		logic               req;
		logic               we;
		logic [ADDR_W-1:0]  addr;
		logic [SL_WR_W-1:0] wdata;
		logic [SL_BE_W-1:0] wbe;
	} l1pd_sl_req_t;

	typedef struct packed {
		l1pd_state_t               st;
		logic                      half;
		logic [2:0]                cnt;
		logic                      way;
		logic [ADDR_W-1:0]         maddr;
		logic [P_LINES-1:0]        p_valid;
		logic [D_WAYS-1:0][D_SETS-1:0] d_valid;
		logic [D_WAYS-1:0][D_SETS-1:0] d_dirty;
		logic [D_SETS-1:0]         lru;
		logic                      pf_rvalid;
		logic [31:0]               pf_rdata;
		logic                      dc_rvalid;
		logic [31:0]               dc_rdata;
		l1pd_sl_req_t              sl;
	} l1pd_regs_t;

endpackage

// File: test/l1pd_sl_model.sv
`timescale 1ns/100ps
`default_nettype none
module l1pd_sl_model (
	// clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         reset_n,
	// request side
	input  wire l1pd_pkg::l1pd_sl_req_t       sl_req,
	input  wire logic [3:0]                   lag,
	// answer side
	output logic                              sl_ack,
	output logic [l1pd_pkg::SL_RD_W-1:0]      sl_rdata
);
	import l1pd_pkg::*;

	logic [3:0] wait_cnt;

	function automatic logic [31:0] word(input logic [31:0] a);
		return {a[15:0] ^ 16'h5A3C, a[15:0]};
	endfunction

	// data only valid with ack; otherwise it toggles so stale use shows
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sl_ack   <= 1'b0;
			wait_cnt <= 4'h0;
			sl_rdata <= '0;
		end else if (sl_req.req && !sl_ack && wait_cnt >= lag) begin
			sl_ack   <= 1'b1;
			wait_cnt <= 4'h0;
			for (int i = 0; i < 8; i++) begin
				sl_rdata[32*i +: 32] <= word(sl_req.addr + 32'(4 * i));
			end
		end else begin
			sl_ack   <= 1'b0;
			wait_cnt <= (sl_req.req && !sl_ack) ? wait_cnt + 4'h1 : 4'h0;
			sl_rdata <= ~sl_rdata;
		end
	end
endmodule
`default_nettype wire

// File: test/l1_program_data_caches_bench.sv
`timescale 1ns/100ps
`default_nettype none
module l1_program_data_caches_bench;
	import l1pd_pkg::*;

	logic               sys_clk = 1'b0;
	logic               reset_n = 1'b0;
	l1pd_core_req_t     pf_req = '0;
	l1pd_core_req_t     dc_req = '0;
	logic               pf_ready, pf_rvalid, dc_ready, dc_rvalid, sl_ack;
	logic [31:0]        pf_rdata, dc_rdata;
	l1pd_sl_req_t       sl_req;
	logic [SL_RD_W-1:0] sl_rdata;
	logic [3:0]         lag = 4'h0;
	logic [31:0]        qp[$], qd[$];
	logic [64:0]        sl_log[$];
	int                 n_fail = 0;
	int                 n_compared = 0;
	int                 cyc;
	logic [31:0]        seed = 32'h0000_003E;
	logic [31:0]        pa, da, d, wm, dd;

	always #5 sys_clk = ~sys_clk;

	l1pd_caches u_dut (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.pf_req(pf_req), .pf_ready(pf_ready),
		.pf_rvalid(pf_rvalid), .pf_rdata(pf_rdata),
		.dc_req(dc_req), .dc_ready(dc_ready),
		.dc_rvalid(dc_rvalid), .dc_rdata(dc_rdata),
		.sl_req(sl_req), .sl_ack(sl_ack), .sl_rdata(sl_rdata)
	);

	l1pd_sl_model u_far (
		.sys_clk(sys_clk), .reset_n(reset_n), .sl_req(sl_req),
		.lag(lag), .sl_ack(sl_ack), .sl_rdata(sl_rdata)
	);

	function automatic logic [31:0] word(input logic [31:0] a);
		return {a[15:0] ^ 16'h5A3C, a[15:0]};
	endfunction

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [64:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task test_done;
		if (n_fail == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// request held until ready is seen high at a falling edge, then through the next rising edge
	task automatic acc(input bit dp, we, input logic [31:0] a, v,
			input logic [3:0] be, output int c);
		l1pd_core_req_t r;
		r = '{1'b1, we, a, v, be};
		lag = 4'(xs() & 32'h3);
		if (dp) dc_req = r; else pf_req = r;
		c = 0;
		@(negedge sys_clk);
		while ((dp ? dc_ready : pf_ready) !== 1'b1) begin
			c++;
			if (c > 200) begin
				n_fail++;
				test_done();
			end
			@(negedge sys_clk);
		end
		@(posedge sys_clk);
		#1;
		r.req = 1'b0;
		if (dp) dc_req = r; else pf_req = r;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic rd(input bit dp, input logic [31:0] a, e);
		if (dp) qd.push_back(e); else qp.push_back(e);
		acc(dp, 1'b0, a, 32'h0, 4'h0, cyc);
	endtask

	task lg(input logic w, input logic [31:0] a, v);
		chk("sl_log", sl_log.size() ? sl_log.pop_front() : 'x, {w, a, v});
	endtask

	// ****************************************************************
	// monitors
	// ****************************************************************
	always @(negedge sys_clk) begin
		if (pf_rvalid === 1'b1)
			chk("pf_rdata", pf_rdata, qp.size() ? qp.pop_front() : 'x);
		if (dc_rvalid === 1'b1)
			chk("dc_rdata", dc_rdata, qd.size() ? qd.pop_front() : 'x);
	end

	// request and ack both stand through the cycle; log mid-cycle
	always @(negedge sys_clk)
		if (sl_req.req === 1'b1 && sl_ack === 1'b1)
			sl_log.push_back({sl_req.we, sl_req.addr,
				sl_req.we ? sl_req.wdata[31:0] : 32'h0});

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		pa = (xs() & 32'hFFFF_F000) | 32'h344;
		da = (xs() & 32'hFFFF_F000) | 32'h0A0;
		rd(0, pa, word(pa));
		chk("stall", cyc >= 5, 1);
		lg(0, pa & ~32'h3F, 0);
		lg(0, (pa & ~32'h3F) + 32'h20, 0);
		rd(0, pa + 4, word(pa + 4));
		chk("hit_cyc", cyc, 0);
		// program writes, present and absent line alike, change nothing
		acc(0, 1, pa, xs(), 4'hF, cyc);
		acc(0, 1, pa ^ 32'h2000, xs(), 4'hF, cyc);
		chk("pf_wr", sl_log.size(), 0);
		rd(0, pa, word(pa));
		chk("pf_keep", cyc, 0);
		rd(1, da, word(da));
		lg(0, da, 0);
		lg(0, da + 32'h10, 0);
		acc(1, 1, da, 32'h0000_7700, 4'h2, cyc);
		d = (word(da) & 32'hFFFF_00FF) | 32'h0000_7700;
		rd(1, da, d);
		chk("wr_hit", sl_log.size(), 0);
		wm = da + 32'h4A;
		dd = xs();
		acc(1, 1, wm, dd, 4'hF, cyc);
		lg(1, wm & ~32'h3, dd);
		rd(1, wm & ~32'h3, word(wm & ~32'h3));
		lg(0, wm & ~32'h1F, 0);
		lg(0, (wm & ~32'h1F) + 32'h10, 0);
		rd(1, da ^ 32'h1000, word(da ^ 32'h1000));
		sl_log.delete();
		// third tag in one set pushes out the dirty line
		rd(1, da ^ 32'h2000, word(da ^ 32'h2000));
		lg(1, da, d);
		lg(1, da + 32'h10, word(da + 32'h10));
		lg(0, da ^ 32'h2000, 0);
		sl_log.delete();
		fork
			rd(0, pa ^ 32'h1000, word(pa ^ 32'h1000));
			rd(1, da ^ 32'h3000, word(da ^ 32'h3000));
		join
		chk("shared", sl_log.size(), 4);
		chk("drain", qp.size() + qd.size(), 0);
		test_done();
	end
endmodule
`default_nettype wire
